// *** src_output_rate_select.sv ***
// output rate selector for converters 6 and 7 with avalon register slave
`timescale 1ns/1ns
//
// Behaviour
// - per converter a 4-bit rw rate code, reset to zero, picks the lock source.
// - code 0000 selects no source; the converter output rate stays unlocked.
// - codes 0001 to 0100 lock to serial output port 0 to 3 rate.
// - code 0101 locks to the dsp core audio rate.
// - code 0110 locks to the first clock generator base rate.
// - codes 0111 and 1000 lock to twice and four times that base rate.
// - codes 1001 and 1011 lock to half and quarter that base rate.
// - codes 1010 and 1100 lock to third and sixth of second generator.
// - converter 6 drives channels 12 and 13; converter 7 drives 14 and 15.
module src_output_rate_select (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // avalon-mm slave
  input wire logic [src_rate_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [src_rate_pkg::BUS_W-1:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [src_rate_pkg::BUS_W-1:0] o_readdata,
  output logic o_waitrequest,
  // rate source pins, asynchronous to i_clock
  input wire logic [3:0] i_port_rate_clk,
  input wire logic i_dsp_rate_clk,
  input wire logic i_cg1_x4_clk,
  input wire logic i_cg2_clk,
  // rate strobes per channel 12..15, and lock state per converter
  output logic [3:0] o_chan_rate_tick,
  output logic [1:0] o_conv_locked
);
  localparam int PIN_N = 7;
  localparam int CW = src_rate_pkg::CODE_W;

  // widens a stored code to a bus word; reserved bits are never kept
  function automatic logic [src_rate_pkg::BUS_W-1:0] code_word(
      input logic [CW-1:0] code);
    code_word = {{(src_rate_pkg::BUS_W - CW){1'b0}}, code};
  endfunction

  // ---- avalon slave: one wait cycle, then the answer
  logic ack_r;
  logic [src_rate_pkg::BUS_W-1:0] rdata_r;
  logic [CW-1:0] code6_r;
  logic [CW-1:0] code7_r;
  logic [CW-1:0] code6_nxt;
  logic [CW-1:0] code7_nxt;

  wire req = i_read || i_write;
  wire hit6 = i_address == src_rate_pkg::OFS_CONV6;
  wire hit7 = i_address == src_rate_pkg::OFS_CONV7;
  wire hit_st = i_address == src_rate_pkg::OFS_STATUS;
  wire wr_lane0 = i_write && ack_r && i_byteenable[0];
  wire wr6 = wr_lane0 && hit6;
  wire wr7 = wr_lane0 && hit7;
  wire [CW-1:0] wcode = i_writedata[src_rate_pkg::CODE_LSB +: CW];

  // reserved bits are not stored, so they read back as zero
  wire [src_rate_pkg::BUS_W-1:0] rd_word =
    hit6 ? code_word(code6_r) :
    hit7 ? code_word(code7_r) :
    hit_st ? {30'h0, o_conv_locked} :
    32'h00000000;

  assign o_waitrequest = req && !ack_r;
  assign code6_nxt = wr6 ? wcode : code6_r;
  assign code7_nxt = wr7 ? wcode : code7_r;
  assign o_readdata = rdata_r;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      code6_r <= src_rate_pkg::CODE_RESET;
      code7_r <= src_rate_pkg::CODE_RESET;
    end else begin
      ack_r <= req && !ack_r;
      if (i_read && !ack_r) begin
        rdata_r <= rd_word;
      end
      code6_r <= code6_nxt;
      code7_r <= code7_nxt;
    end
  end

  // ---- pin synchronisers and rising-edge strobes
  // the edge detector reads only the second and third stage
  logic [PIN_N-1:0] meta_r;
  logic [PIN_N-1:0] sync_r;
  logic [PIN_N-1:0] last_r;
  wire [PIN_N-1:0] pins = {i_cg2_clk, i_cg1_x4_clk, i_dsp_rate_clk,
                           i_port_rate_clk};
  wire [PIN_N-1:0] pin_rise = sync_r & ~last_r;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // ---- derived rates; all slower rates are one-cycle enables
  // the first generator is fed at four times its base rate so that the
  // doubled and quadrupled rates need no multiplier
  wire cg1_rise = pin_rise[5];
  wire cg2_rise = pin_rise[6];
  logic t_x2;
  logic t_base;
  logic t_half;
  logic t_quarter;
  logic t_third;
  logic t_sixth;

  src_tick_divider #(.N(src_rate_pkg::DIV_X2)) div_x2 (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_tick(cg1_rise),
    .o_tick(t_x2)
  );
  src_tick_divider #(.N(src_rate_pkg::DIV_BASE)) div_base (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_tick(cg1_rise),
    .o_tick(t_base)
  );
  src_tick_divider #(.N(src_rate_pkg::DIV_HALF)) div_half (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_tick(cg1_rise),
    .o_tick(t_half)
  );
  src_tick_divider #(.N(src_rate_pkg::DIV_QUARTER)) div_quarter (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_tick(cg1_rise),
    .o_tick(t_quarter)
  );
  src_tick_divider #(.N(src_rate_pkg::DIV_THIRD)) div_third (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_tick(cg2_rise),
    .o_tick(t_third)
  );
  src_tick_divider #(.N(src_rate_pkg::DIV_SIXTH)) div_sixth (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_tick(cg2_rise),
    .o_tick(t_sixth)
  );

  src_rate_pkg::rate_ticks_type ticks;
  assign ticks = {pin_rise[3:0], pin_rise[4], t_base, t_x2, cg1_rise,
                  t_half, t_quarter, t_third, t_sixth};

  // ---- one selector per converter
  logic conv6_tick;
  logic conv7_tick;

  src_rate_mux #(.CODE_W(CW)) mux6 (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_code(code6_r),
    .i_ticks(ticks),
    .o_rate_tick(conv6_tick),
    .o_locked(o_conv_locked[0])
  );
  src_rate_mux #(.CODE_W(CW)) mux7 (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_code(code7_r),
    .i_ticks(ticks),
    .o_rate_tick(conv7_tick),
    .o_locked(o_conv_locked[1])
  );

  // each converter serves one stereo pair
  assign o_chan_rate_tick = {conv7_tick, conv7_tick,
                             conv6_tick, conv6_tick};

  // ---- checks
  sequence wait_s;
    req && !ack_r;
  endsequence

  sequence answer_s;
    req && !o_waitrequest;
  endsequence

  bus_one_wait_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    wait_s ##1 req |-> answer_s)
    else $error("bus answer not after one wait cycle");

  reset_code_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    $rose(i_nrst) |-> code6_r == 4'h0 && code7_r == 4'h0)
    else $error("rate codes not cleared by reset");

  write_code_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    wr6 |=> code6_r == $past(i_writedata[3:0]) && $stable(code7_r))
    else $error("rate code write lost");

  write7_code_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    wr7 |=> code7_r == $past(i_writedata[3:0]) && $stable(code6_r))
    else $error("converter 7 rate code write lost");

  lane_gate_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    i_write && ack_r && !i_byteenable[0] |=> $stable(code6_r) && $stable(code7_r))
    else $error("write without lane zero changed a code");

  none_silent_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code6_r == 4'h0 ##1 code6_r == 4'h0 |-> !o_chan_rate_tick[0]
      && !o_conv_locked[0])
    else $error("strobe or lock with no source selected");

  port_follow_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code6_r == 4'h3 |-> ##1 o_chan_rate_tick[0] == $past(pin_rise[2]))
    else $error("converter 6 not following serial port 2");

  port_zero_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code7_r == 4'h1 |-> ##1 o_chan_rate_tick[2] == $past(pin_rise[0]))
    else $error("converter 7 not following serial port 0");

  dsp_follow_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code7_r == 4'h5 |-> ##1 o_chan_rate_tick[2] == $past(pin_rise[4]))
    else $error("converter 7 not following dsp rate");

  cg1_base_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code6_r == 4'h6 && t_base |=> o_chan_rate_tick[1])
    else $error("base generator rate not followed");

  cg1_multi_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code7_r == 4'h8 |-> ##1 o_chan_rate_tick[3] == $past(cg1_rise))
    else $error("quadrupled generator rate wrong");

  cg1_double_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code7_r == 4'h7 |-> ##1 o_chan_rate_tick[3] == $past(t_x2))
    else $error("doubled generator rate wrong");

  cg1_frac_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code6_r == 4'hB |-> ##1 o_chan_rate_tick[0] == $past(t_quarter))
    else $error("quarter generator rate wrong");

  cg1_half_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code6_r == 4'h9 |-> ##1 o_chan_rate_tick[0] == $past(t_half))
    else $error("halved generator rate wrong");

  cg2_frac_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code7_r == 4'hA |-> ##1 o_chan_rate_tick[2] == $past(t_third))
    else $error("third of second generator wrong");

  cg2_sixth_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code7_r == 4'hC |-> ##1 o_chan_rate_tick[2] == $past(t_sixth))
    else $error("sixth of second generator wrong");

  pair_map_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    !src_rate_pkg::code_valid(code6_r) && code7_r == 4'h1 && pin_rise[0]
      |=> o_chan_rate_tick == 4'hC)
    else $error("converter strobes on wrong channel pair");

  undef_code_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    code6_r >= 4'hD ##1 code6_r >= 4'hD |-> !o_chan_rate_tick[0])
    else $error("undefined code produced a strobe");

  rsvd_zero_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    i_read && !ack_r && (hit6 || hit7) |=> o_readdata[31:4] == 28'h0000000)
    else $error("reserved bits read nonzero");

  lock_drop6_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    $changed(code6_r) |=> !o_conv_locked[0])
    else $error("converter 6 kept lock across a code change");

  lock_drop7_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    $changed(code7_r) |=> !o_conv_locked[1])
    else $error("converter 7 kept lock across a code change");

  status_read_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    i_read && !ack_r && hit_st
      |=> o_readdata == {30'h0, $past(o_conv_locked)})
    else $error("status read does not show the lock state");

  unmapped_zero_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    i_read && !ack_r && !(hit6 || hit7 || hit_st) |=> o_readdata == 32'h0)
    else $error("unmapped read returned nonzero");
endmodule

// *** src_rate_pkg.sv ***
// shared constants and types for the converter output rate selector
package src_rate_pkg;
  localparam int CODE_W = 4;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 4;
  localparam int CONV_N = 2;
  // byte offsets of the register words
  localparam logic [3:0] OFS_CONV6 = 4'h0;
  localparam logic [3:0] OFS_CONV7 = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam int CODE_LSB = 0;
  // rate dividers, counted in strobes of the fastest input of each generator
  localparam int DIV_X2 = 2;
  localparam int DIV_BASE = 4;
  localparam int DIV_HALF = 8;
  localparam int DIV_QUARTER = 16;
  localparam int DIV_THIRD = 3;
  localparam int DIV_SIXTH = 6;

  typedef enum logic [3:0] {
    RATE_NONE = 4'h0,
    RATE_PORT0 = 4'h1,
    RATE_PORT1 = 4'h2,
    RATE_PORT2 = 4'h3,
    RATE_PORT3 = 4'h4,
    RATE_DSP = 4'h5,
    RATE_CG1 = 4'h6,
    RATE_CG1_X2 = 4'h7,
    RATE_CG1_X4 = 4'h8,
    RATE_CG1_HALF = 4'h9,
    RATE_CG2_THIRD = 4'hA,
    RATE_CG1_QUARTER = 4'hB,
    RATE_CG2_SIXTH = 4'hC
  } rate_code_type;

  // one-cycle rate strobes, one per selectable source
  typedef struct packed {
    logic [3:0] port;
    logic dsp;
    logic cg1_base;
    logic cg1_x2;
    logic cg1_x4;
    logic cg1_half;
    logic cg1_quarter;
    logic cg2_third;
    logic cg2_sixth;
  } rate_ticks_type;

  typedef enum logic [1:0] {
    LOCK_IDLE = 2'h0,
    LOCK_WAIT = 2'h1,
    LOCK_HELD = 2'h3
  } lock_state_type;

  function automatic logic code_valid(input logic [3:0] code);
    code_valid = (code != RATE_NONE) && (code <= RATE_CG2_SIXTH);
  endfunction
endpackage

// *** src_tick_divider.sv ***
// strobe divider: one output strobe for every n input strobes
`timescale 1ns/1ns
module src_tick_divider #(
  parameter int N = 2
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // strobes
  input wire logic i_tick,
  output logic o_tick
);
  localparam int CW = $clog2(N);

  generate
    if (N < 2) begin : g_bad_n
      $error("divider factor below two");
    end
  endgenerate

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire wrap = i_tick && (cnt_r == CW'(N - 1));

  assign cnt_nxt = !i_tick ? cnt_r : (wrap ? '0 : cnt_r + CW'(1));

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_tick <= wrap;
    end
  end

  div_spacing_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_tick |-> $past(cnt_r) == CW'(N - 1))
    else $error("divider strobe off its count");
endmodule

// *** src_rate_mux.sv ***
// per-converter rate source select and lock tracking
`timescale 1ns/1ns
module src_rate_mux #(
  parameter int CODE_W = src_rate_pkg::CODE_W
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // selection and sources
  input wire logic [CODE_W-1:0] i_code,
  input wire src_rate_pkg::rate_ticks_type i_ticks,
  // results
  output logic o_rate_tick,
  output logic o_locked
);
  generate
    if (CODE_W != 4) begin : g_bad_w
      $error("target rate code must be four bits");
    end
  endgenerate

  function automatic logic pick(input logic [3:0] code,
                                input src_rate_pkg::rate_ticks_type t);
    case (code)
      src_rate_pkg::RATE_PORT0: pick = t.port[0];
      src_rate_pkg::RATE_PORT1: pick = t.port[1];
      src_rate_pkg::RATE_PORT2: pick = t.port[2];
      src_rate_pkg::RATE_PORT3: pick = t.port[3];
      src_rate_pkg::RATE_DSP: pick = t.dsp;
      src_rate_pkg::RATE_CG1: pick = t.cg1_base;
      src_rate_pkg::RATE_CG1_X2: pick = t.cg1_x2;
      src_rate_pkg::RATE_CG1_X4: pick = t.cg1_x4;
      src_rate_pkg::RATE_CG1_HALF: pick = t.cg1_half;
      src_rate_pkg::RATE_CG2_THIRD: pick = t.cg2_third;
      src_rate_pkg::RATE_CG1_QUARTER: pick = t.cg1_quarter;
      src_rate_pkg::RATE_CG2_SIXTH: pick = t.cg2_sixth;
      default: pick = 1'b0; // none and undefined codes
    endcase
  endfunction

  src_rate_pkg::lock_state_type state_r;
  src_rate_pkg::lock_state_type state_nxt;
  logic [CODE_W-1:0] code_seen_r;

  wire valid = src_rate_pkg::code_valid(i_code);
  wire sel_tick = pick(i_code, i_ticks);
  wire changed = i_code != code_seen_r;

  // a new code drops lock until the new source has shown a strobe
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      src_rate_pkg::LOCK_IDLE: if (valid) state_nxt = src_rate_pkg::LOCK_WAIT;
      src_rate_pkg::LOCK_WAIT:
        if (sel_tick) state_nxt = src_rate_pkg::LOCK_HELD;
      src_rate_pkg::LOCK_HELD: state_nxt = src_rate_pkg::LOCK_HELD;
      default: state_nxt = src_rate_pkg::LOCK_IDLE;
    endcase
    if (!valid || changed) begin
      state_nxt = src_rate_pkg::LOCK_IDLE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r <= src_rate_pkg::LOCK_IDLE;
      code_seen_r <= '0;
      o_rate_tick <= 1'b0;
    end else begin
      state_r <= state_nxt;
      code_seen_r <= i_code;
      o_rate_tick <= sel_tick;
    end
  end

  assign o_locked = state_r == src_rate_pkg::LOCK_HELD;

  sequence armed_s;
    valid && !changed && state_r == src_rate_pkg::LOCK_WAIT;
  endsequence

  sequence first_tick_s;
    armed_s ##0 sel_tick;
  endsequence

  lock_on_tick_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    first_tick_s ##1 ($stable(i_code)) |-> o_locked)
    else $error("lock not taken on first source strobe");

  unlock_bad_a: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    !valid |=> !o_locked && !o_rate_tick)
    else $error("undefined or empty code kept a lock");
endmodule

// *** tb_top.sv ***
// self-checking bench for the converter output rate selector
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[ERR] %0t got %0h expected %0h", $time, got, exp); \
  end \
end
module tb_top;
  // edges per source burst; a multiple of every divisor, so phase is moot
  localparam int K = 48;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_address = 4'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic [6:0] src = 7'h00;
  logic [3:0] o_chan_rate_tick;
  logic [1:0] o_conv_locked;
  int n_errors = 0;
  int total_checks = 0;
  int cnt [4] = '{0, 0, 0, 0};

  always #50 i_clock = ~i_clock;

  src_output_rate_select src_output_rate_select_inst (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_writedata(i_writedata),
    .i_byteenable(i_byteenable),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .i_port_rate_clk(src[3:0]),
    .i_dsp_rate_clk(src[4]),
    .i_cg1_x4_clk(src[5]),
    .i_cg2_clk(src[6]),
    .o_chan_rate_tick(o_chan_rate_tick),
    .o_conv_locked(o_conv_locked)
  );

  always @(posedge i_clock) begin
    if (i_nrst === 1'b1 && $isunknown(o_chan_rate_tick)) begin
      n_errors++;
      $display("[ERR] %0t unknown rate strobe", $time);
    end
    for (int i = 0; i < 4; i++) begin
      if (o_chan_rate_tick[i] === 1'b1) begin
        cnt[i] = cnt[i] + 1;
      end
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // waitrequest and read data are taken at the rising edge ending a cycle
  task automatic bus_xfer(input logic wr, input logic [3:0] addr,
      input logic [31:0] wdata, input logic [3:0] be,
      output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge i_clock);
    i_address <= addr;
    i_writedata <= wdata;
    i_byteenable <= be;
    i_write <= wr;
    i_read <= !wr;
    @(posedge i_clock);
    while (o_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge i_clock);
    end
    if (n == 20) begin
      n_errors++;
      $display("[ERR] %0t bus answer missing", $time);
    end
    rdata = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, d, be, dummy);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus_xfer(1'b0, a, 32'h0, 4'hF, got);
    `CHECK(got, exp)
  endtask

  // high and low two cycles each, then time for the sync chain to drain
  task automatic pulse_pin(input int p, input int n);
    repeat (n) begin
      @(posedge i_clock);
      src[p] <= 1'b1;
      repeat (2) @(posedge i_clock);
      src[p] <= 1'b0;
      @(posedge i_clock);
    end
    repeat (8) @(posedge i_clock);
  endtask

  // pins: 0..3 ports, 4 dsp, 5 first generator at x4, 6 second generator
  function automatic int exp_ticks(input logic [3:0] c, input int p);
    case (c)
      4'h1, 4'h2, 4'h3, 4'h4: exp_ticks = (p == int'(c) - 1) ? K : 0;
      4'h5: exp_ticks = (p == 4) ? K : 0;
      4'h6: exp_ticks = (p == 5) ? K / 4 : 0;
      4'h7: exp_ticks = (p == 5) ? K / 2 : 0;
      4'h8: exp_ticks = (p == 5) ? K : 0;
      4'h9: exp_ticks = (p == 5) ? K / 8 : 0;
      4'hB: exp_ticks = (p == 5) ? K / 16 : 0;
      4'hA: exp_ticks = (p == 6) ? K / 3 : 0;
      4'hC: exp_ticks = (p == 6) ? K / 6 : 0;
      default: exp_ticks = 0;
    endcase
  endfunction

  task automatic test_reset_values;
    rd_chk(src_rate_pkg::OFS_CONV6, 32'h0);
    rd_chk(src_rate_pkg::OFS_CONV7, 32'h0);
    `CHECK(o_conv_locked, 2'b00)
  endtask

  task automatic test_register_access;
    wr(src_rate_pkg::OFS_CONV6, 32'hFFFF_FFF5, 4'hF);
    rd_chk(src_rate_pkg::OFS_CONV6, 32'h5);
    wr(src_rate_pkg::OFS_CONV7, 32'hA, 4'hE);
    rd_chk(src_rate_pkg::OFS_CONV7, 32'h0);
    wr(src_rate_pkg::OFS_CONV7, 32'hD, 4'hF);
    rd_chk(src_rate_pkg::OFS_CONV7, 32'hD);
    wr(4'hC, 32'h3, 4'hF);
    rd_chk(4'hC, 32'h0);
    wr(src_rate_pkg::OFS_STATUS, 32'h3, 4'hF);
    rd_chk(src_rate_pkg::OFS_STATUS, 32'h0);
    rd_chk(src_rate_pkg::OFS_CONV6, 32'h5);
  endtask

  // converter 7 runs the mirrored code, so both walk all sixteen codes
  task automatic test_code_table;
    logic [3:0] c;
    logic [3:0] c7;
    logic [1:0] lk;
    int base [4];
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      c7 = ~c;
      wr(src_rate_pkg::OFS_CONV6, {28'h0, c}, 4'hF);
      wr(src_rate_pkg::OFS_CONV7, {28'h0, c7}, 4'hF);
      for (int p = 0; p < 7; p++) begin
        base = cnt;
        pulse_pin(p, K);
        for (int b = 0; b < 4; b++) begin
          `CHECK(cnt[b] - base[b], exp_ticks(b < 2 ? c : c7, p))
        end
      end
      lk[0] = (c >= 4'h1 && c <= 4'hC);
      lk[1] = (c7 >= 4'h1 && c7 <= 4'hC);
      `CHECK(o_conv_locked, lk)
      rd_chk(src_rate_pkg::OFS_STATUS, {30'h0, lk});
    end
  endtask

  task automatic test_mid_reset;
    wr(src_rate_pkg::OFS_CONV6, 32'h6, 4'hF);
    pulse_pin(5, 8);
    `CHECK(o_conv_locked[0], 1'b1)
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    `CHECK(o_conv_locked, 2'b00)
    rd_chk(src_rate_pkg::OFS_CONV6, 32'h0);
  endtask

  initial begin
    #(40000 * 100);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    test_reset_values();
    test_register_access();
    test_code_table();
    test_mid_reset();
    give_verdict();
  end
endmodule
